// file: rtl/cie_pkg.sv
// package of the core interrupt expansion block: offsets, layouts, codes
// assumes a 32-bit AHB-Lite register bus and a 125 MHz core clock
package cie_pkg;

   // ************************************************************
   // register offsets (byte addresses)
   // ************************************************************
   localparam logic [7:0] CIE_OFS_FLAG   = 8'h00;
   localparam logic [7:0] CIE_OFS_ACK    = 8'h04;
   localparam logic [7:0] CIE_OFS_ENABLE = 8'h08;
   localparam logic [7:0] CIE_OFS_MASK   = 8'h0c;
   localparam logic [7:0] CIE_OFS_GMASK  = 8'h10;
   localparam logic [7:0] CIE_OFS_CODE   = 8'h14;
   localparam logic [7:0] CIE_OFS_LINES  = 8'h18;

   // ************************************************************
   // sources folded on core line one, in priority order
   // ************************************************************
   localparam int CIE_NSRC  = 8;
   localparam int CIE_NLINE = 6;
   // index: 0 power a, 1 power b, 2 converter, 3 pin a, 4 pin b,
   //        5 serial periph, 6 serial rx, 7 serial tx
   localparam logic [4:0] CIE_FLAG_POS [CIE_NSRC] = '{
      5'd0, 5'd16, 5'd1, 5'd2, 5'd3, 5'd4, 5'd5, 5'd6};
   localparam logic [15:0] CIE_SRC_CODE [CIE_NSRC] = '{
      16'h0020, 16'h0019, 16'h0004, 16'h0001, 16'h0011, 16'h0005,
      16'h0006, 16'h0007};
   localparam logic [15:0] CIE_CODE_NONE = 16'h0000;

   // ************************************************************
   // cpu vectors
   // ************************************************************
   localparam logic [15:0] CIE_VEC_RESET = 16'h0000;
   localparam logic [15:0] CIE_VEC_TRAP  = 16'h0022;
   localparam logic [15:0] CIE_VEC_NMI   = 16'h0024;
   localparam logic [15:0] CIE_VEC_EMU   = 16'h0026;

   localparam logic [31:0] CIE_RST_WORD  = 32'h0000_0000;
   localparam logic [5:0]  CIE_RST_MASK  = 6'h00;
   localparam logic        CIE_RST_GMASK = 1'b1;

   typedef struct packed {
      logic        valid;
      logic [15:0] vec;
   } cie_branch_type;

   typedef enum logic [1:0] {
      CIE_KIND_NONE = 2'b00,
      CIE_KIND_SWI  = 2'b01,
      CIE_KIND_TRAP = 2'b10
   } cie_kind_type;

endpackage

// file: rtl/cie_pick.sv
// fixed-priority picker: vector code of the first pending source
// assumes the request vector is ordered highest priority first
`timescale 1ns/100ps
`default_nettype none
module cie_pick
   import cie_pkg::*;
(
   input  wire logic [CIE_NSRC-1:0] pend_i,
   output logic      [15:0]         code_o,
   output logic                     any_o
);

   // ************************************************************
   // scan from lowest priority upward so the first source wins
   // ************************************************************
   always_comb begin
      code_o = CIE_CODE_NONE;
      any_o  = 1'b0;
      for (int i = CIE_NSRC - 1; i >= 0; i--) begin
         if (pend_i[i]) begin
            code_o = CIE_SRC_CODE[i];
            any_o  = 1'b1;
         end
      end
   end

endmodule
`default_nettype wire

// file: rtl/cie_top.sv
// core interrupt expansion: reset, software traps and peripheral folding
// assumes pins are asynchronous, peripheral events are clk_i pulses
//
// Behaviour
// - reset acts at once and leaves maskable interrupts disabled until software enables; pin reset passes the two-flop synchroniser first
// - reset from external pin or watchdog timeout, both vector 0000h
// - pin and power interrupts gated by own enable and core line mask
// - peripheral events gated by own enable and core line mask
// - software interrupt branches to operand vector and sets global mask
// - nonmaskable instruction branches to 24h, sets global mask, software only
// - trap branches to 22h, global mask unchanged
// - emulator trap raised by interrupt or trap instruction, vector 0026h
// - all peripheral requests folded onto six core interrupt lines
// - each source on a shared line has a distinct vector code
// - fixed priority: reset, emulator trap, nonmaskable, then peripherals
// - line 0002h order: power a, power b, converter, pins, serial periph, rx
// - pin a 0.2/0001h, pin b 0.3/0011h, power b 2.0/0019h
// - serial peripheral at flag 0.4, code 0005h
// - serial transmit at flag 0.6, code 0007h, after serial receive
//
// Decided for this implementation: the AHB-Lite slave port and the register addresses.
`timescale 1ns/100ps
`default_nettype none
module cie_top
   import cie_pkg::*;
(
   input  wire logic                 clk_i,
   input  wire logic                 resetn_i,
   input  wire logic                 en_i,
   // ahb-lite slave
   input  wire logic                 hsel_i,
   input  wire logic [7:0]           haddr_i,
   input  wire logic [1:0]           htrans_i,
   input  wire logic                 hwrite_i,
   input  wire logic [2:0]           hsize_i,
   input  wire logic [31:0]          hwdata_i,
   input  wire logic                 hready_i,
   output logic      [31:0]          hrdata_o,
   output logic                      hreadyout_o,
   output logic                      hresp_o,
   // external pins, asynchronous
   input  wire logic                 reset_pin_n_i,
   input  wire logic                 ext_pin_irq_a_i,
   input  wire logic                 ext_pin_irq_b_i,
   input  wire logic                 power_protect_irq_a_i,
   input  wire logic                 power_protect_irq_b_i,
   // on-chip events, one-cycle pulses on clk_i
   input  wire logic                 watchdog_timeout_i,
   input  wire logic                 converter_irq_i,
   input  wire logic                 serial_periph_irq_i,
   input  wire logic                 serial_rx_irq_i,
   input  wire logic                 serial_tx_irq_i,
   input  wire logic [CIE_NLINE-1:1] other_line_req_i,
   // instruction stream
   input  wire logic                 sw_interrupt_instr_i,
   input  wire logic [15:0]          sw_interrupt_vec_i,
   input  wire logic                 nmi_instr_i,
   input  wire logic                 trap_instr_i,
   input  wire logic                 emu_trap_req_i,
   // cpu side
   output logic                      cpu_reset_o,
   output cie_branch_type            branch_o,
   output logic [CIE_NLINE-1:0]      core_irq_lines_o,
   output logic [15:0]               peripheral_vector_code_o,
   output logic                      global_irq_mask_flag_o
);

   // ************************************************************
   // pin synchronisers
   // ************************************************************
   logic [4:0] pin_meta_q;
   logic [4:0] pin_sync_q;
   logic [3:0] pin_prev_q;
   logic [4:0] pin_raw;

   assign pin_raw = {~reset_pin_n_i, power_protect_irq_b_i, power_protect_irq_a_i,
                     ext_pin_irq_b_i, ext_pin_irq_a_i};

   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         pin_meta_q <= 5'h00;
         pin_sync_q <= 5'h00;
         pin_prev_q <= 4'h0;
      end else if (en_i) begin
         pin_meta_q <= pin_raw;
         pin_sync_q <= pin_meta_q;
         pin_prev_q <= pin_sync_q[3:0];
      end
   end

   logic [3:0] pin_rise;
   assign pin_rise = pin_sync_q[3:0] & ~pin_prev_q;

   // ************************************************************
   // per-source events in priority order
   // ************************************************************
   logic [CIE_NSRC-1:0] src_evt;
   assign src_evt = {serial_tx_irq_i, serial_rx_irq_i, serial_periph_irq_i,
                     pin_rise[1], pin_rise[0], converter_irq_i,
                     pin_rise[3], pin_rise[2]};

   // ************************************************************
   // bus address phase capture
   // ************************************************************
   logic       ph_wr_q;
   logic [7:0] ph_addr_q;
   logic       take;

   assign take = hsel_i && htrans_i[1] && hready_i;

   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         ph_wr_q   <= 1'b0;
         ph_addr_q <= 8'h00;
      end else if (en_i) begin
         ph_wr_q   <= take && hwrite_i;
         ph_addr_q <= haddr_i;
      end
   end

   logic wr_ack;
   logic wr_enable;
   logic wr_mask;
   logic wr_gmask;

   assign wr_ack    = ph_wr_q && (ph_addr_q == CIE_OFS_ACK);
   assign wr_enable = ph_wr_q && (ph_addr_q == CIE_OFS_ENABLE);
   assign wr_mask   = ph_wr_q && (ph_addr_q == CIE_OFS_MASK);
   assign wr_gmask  = ph_wr_q && (ph_addr_q == CIE_OFS_GMASK);

   // ************************************************************
   // enables and request flags, one slice per source
   // ************************************************************
   logic [31:0]         enable_q;
   logic [31:0]         flag_q;
   logic [CIE_NSRC-1:0] pend;

   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         enable_q <= CIE_RST_WORD;
      end else if (en_i && wr_enable) begin
         enable_q <= hwdata_i;
      end
   end

   genvar g;
   generate
      for (g = 0; g < CIE_NSRC; g++) begin : g_src
         localparam logic [4:0] POS = CIE_FLAG_POS[g];
         logic set;
         assign set = src_evt[g] && enable_q[POS];
         always_ff @(posedge clk_i) begin
            if (!resetn_i) begin
               flag_q[POS] <= 1'b0;
            end else if (en_i) begin
               if (set) begin
                  flag_q[POS] <= 1'b1;
               end else if (wr_ack && hwdata_i[POS]) begin
                  flag_q[POS] <= 1'b0;
               end
            end
         end
         assign pend[g] = flag_q[POS] && enable_q[POS];
      end
   endgenerate

   // unused flag positions stay zero
   generate
      for (g = 0; g < 32; g++) begin : g_unused
         if (g != 0 && g != 16 && (g < 1 || g > 6)) begin : g_zero
            always_ff @(posedge clk_i) begin
               flag_q[g] <= 1'b0;
            end
         end
      end
   endgenerate

   // ************************************************************
   // vector code of line one
   // ************************************************************
   logic [15:0] pick_code;
   logic        pick_any;

   cie_pick u_pick (
      .pend_i (pend),
      .code_o (pick_code),
      .any_o  (pick_any)
   );

   // ************************************************************
   // reset and software branch arbitration
   // ************************************************************
   logic reset_req;
   assign reset_req = pin_sync_q[4] || watchdog_timeout_i;

   cie_branch_type branch_d;
   cie_kind_type   kind_d;

   // reset outranks emulator trap, which outranks the nonmaskable call
   always_comb begin
      branch_d = '{valid: 1'b0, vec: CIE_VEC_RESET};
      kind_d   = CIE_KIND_NONE;
      if (reset_req) begin
         branch_d = '{valid: 1'b1, vec: CIE_VEC_RESET};
      end else if (emu_trap_req_i && (sw_interrupt_instr_i || trap_instr_i)) begin
         branch_d = '{valid: 1'b1, vec: CIE_VEC_EMU};
         kind_d   = sw_interrupt_instr_i ? CIE_KIND_SWI : CIE_KIND_TRAP;
      end else if (nmi_instr_i) begin
         branch_d = '{valid: 1'b1, vec: CIE_VEC_NMI};
         kind_d   = CIE_KIND_SWI;
      end else if (sw_interrupt_instr_i) begin
         branch_d = '{valid: 1'b1, vec: sw_interrupt_vec_i};
         kind_d   = CIE_KIND_SWI;
      end else if (trap_instr_i) begin
         branch_d = '{valid: 1'b1, vec: CIE_VEC_TRAP};
         kind_d   = CIE_KIND_TRAP;
      end
   end

   cie_branch_type branch_q;
   logic           cpu_reset_q;

   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         branch_q    <= '{valid: 1'b0, vec: CIE_VEC_RESET};
         cpu_reset_q <= 1'b1;
      end else if (en_i) begin
         branch_q    <= branch_d;
         cpu_reset_q <= reset_req;
      end
   end

   // ************************************************************
   // global mask and core line mask
   // ************************************************************
   logic                 gmask_q;
   logic [CIE_NLINE-1:0] line_mask_q;

   // a set from an instruction or reset wins over a software write
   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         gmask_q <= CIE_RST_GMASK;
      end else if (en_i) begin
         case (kind_d)
            CIE_KIND_SWI:  gmask_q <= 1'b1;
            CIE_KIND_TRAP: gmask_q <= reset_req ? 1'b1 : gmask_q;
            default: begin
               if (reset_req) begin
                  gmask_q <= 1'b1;
               end else if (wr_gmask) begin
                  gmask_q <= hwdata_i[0];
               end
            end
         endcase
      end
   end

   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         line_mask_q <= CIE_RST_MASK;
      end else if (en_i) begin
         if (reset_req) begin
            line_mask_q <= CIE_RST_MASK;
         end else if (wr_mask) begin
            line_mask_q <= hwdata_i[CIE_NLINE-1:0];
         end
      end
   end

   // ************************************************************
   // core lines and vector code registers
   // ************************************************************
   logic [CIE_NLINE-1:0] raw_lines;
   logic [CIE_NLINE-1:0] lines_q;
   logic [15:0]          code_q;

   assign raw_lines = {other_line_req_i, pick_any};

   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         lines_q <= 6'h00;
         code_q  <= CIE_CODE_NONE;
      end else if (en_i) begin
         // lines still show when the global flag is set; the cpu gates on it
         lines_q <= raw_lines & line_mask_q;
         code_q  <= pick_code;
      end
   end

   // ************************************************************
   // bus read data, registered in the address phase
   // ************************************************************
   logic [31:0] rdata_q;
   logic [31:0] rdata_d;

   always_comb begin
      case (haddr_i)
         CIE_OFS_FLAG:   rdata_d = flag_q;
         CIE_OFS_ENABLE: rdata_d = enable_q;
         CIE_OFS_MASK:   rdata_d = {26'h0, line_mask_q};
         CIE_OFS_GMASK:  rdata_d = {31'h0, gmask_q};
         CIE_OFS_CODE:   rdata_d = {16'h0, pick_code};
         CIE_OFS_LINES:  rdata_d = {26'h0, lines_q};
         default:        rdata_d = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         rdata_q <= 32'h0000_0000;
      end else if (en_i && take && !hwrite_i) begin
         rdata_q <= rdata_d;
      end
   end

   // ************************************************************
   // outputs
   // ************************************************************
   logic hready_q;
   logic hresp_q;

   // zero wait state slave, always okay
   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         hready_q <= 1'b1;
         hresp_q  <= 1'b0;
      end else begin
         hready_q <= 1'b1;
         hresp_q  <= 1'b0;
      end
   end

   assign hrdata_o                 = rdata_q;
   assign hreadyout_o              = hready_q;
   assign hresp_o                  = hresp_q;
   assign cpu_reset_o              = cpu_reset_q;
   assign branch_o                 = branch_q;
   assign core_irq_lines_o         = lines_q;
   assign peripheral_vector_code_o = code_q;
   assign global_irq_mask_flag_o   = gmask_q;

endmodule
`default_nettype wire

// file: testbench/cie_src_model.sv
// source model: external pins and on-chip peripheral event pulses
// assumes fire_i bits are one-cycle commands, in cie_top source order
`timescale 1ns/100ps
`default_nettype none
module cie_src_model (
   input  wire logic       clk_i,
   input  wire logic [7:0] fire_i,
   output logic      [7:0] src_o
);
   // ************************************************************
   // sources
   // ************************************************************
   // pins hold long enough for the two-flop sync to see the rise
   localparam logic [7:0] PIN_BITS = 8'h1b;
   logic [7:0] hold_q [3] = '{default: 8'h00};
   always_ff @(posedge clk_i) begin
      hold_q[0] <= fire_i & PIN_BITS;
      hold_q[1] <= hold_q[0];
      hold_q[2] <= hold_q[1];
   end
   // peripheral events are single pulses, one source per bit
   assign src_o = fire_i | hold_q[0] | hold_q[1] | hold_q[2];
endmodule
`default_nettype wire

// file: testbench/cie_top_assertions.sv
// checker of cie_top: branches, reset requests and vector codes
// assumes it is bound to cie_top and sees only its ports
`timescale 1ns/100ps
`default_nettype none
module cie_top_assertions
   import cie_pkg::*;
(
   input wire logic           clk_i,
   input wire logic           resetn_i,
   input wire logic           en_i,
   input wire logic           hreadyout_o,
   input wire logic           hresp_o,
   input wire logic           reset_pin_n_i,
   input wire logic           watchdog_timeout_i,
   input wire logic           sw_interrupt_instr_i,
   input wire logic [15:0]    sw_interrupt_vec_i,
   input wire logic           nmi_instr_i,
   input wire logic           trap_instr_i,
   input wire logic           emu_trap_req_i,
   input wire logic           cpu_reset_o,
   input wire cie_branch_type branch_o,
   input wire logic [15:0]    peripheral_vector_code_o,
   input wire logic           global_irq_mask_flag_o
);
   // ************************************************************
   // properties
   // ************************************************************
   default clocking dc @(posedge clk_i); endclocking
   default disable iff (!resetn_i);
   // no reset request lately, so nothing outranks the instruction
   sequence s_calm;
      (en_i && reset_pin_n_i && !watchdog_timeout_i)[*4];
   endsequence
   sequence s_emu;
      emu_trap_req_i && (sw_interrupt_instr_i || trap_instr_i);
   endsequence
   property p_trap;
      s_calm ##0 (trap_instr_i && !sw_interrupt_instr_i && !nmi_instr_i && !emu_trap_req_i)
      |=> branch_o == {1'b1, 16'h0022} && $stable(global_irq_mask_flag_o);
   endproperty
   property p_nmi;
      s_calm ##0 (nmi_instr_i && !(emu_trap_req_i && (sw_interrupt_instr_i || trap_instr_i)))
      |=> branch_o == {1'b1, 16'h0024} && global_irq_mask_flag_o;
   endproperty
   property p_swi;
      s_calm ##0 (sw_interrupt_instr_i && !nmi_instr_i && !emu_trap_req_i)
      |=> branch_o == {1'b1, $past(sw_interrupt_vec_i)} && global_irq_mask_flag_o;
   endproperty
   property p_emu;
      s_calm ##0 s_emu |=> branch_o == {1'b1, 16'h0026};
   endproperty
   property p_wdt;
      en_i && watchdog_timeout_i |=> cpu_reset_o && global_irq_mask_flag_o;
   endproperty
   property p_pin;
      $fell(reset_pin_n_i) |-> ##[1:4] cpu_reset_o;
   endproperty
   property p_rst_gm;
      cpu_reset_o |-> global_irq_mask_flag_o;
   endproperty
   property p_vcode;
      peripheral_vector_code_o inside {16'h0000, 16'h0020, 16'h0019, 16'h0004,
                                       16'h0001, 16'h0011, 16'h0005, 16'h0006, 16'h0007};
   endproperty
   property p_bus;
      hreadyout_o && !hresp_o;
   endproperty
   a_trap: assert property (p_trap) else $error("trap branch wrong");
   a_nmi: assert property (p_nmi) else $error("nmi branch wrong");
   a_swi: assert property (p_swi) else $error("software interrupt branch wrong");
   a_emu: assert property (p_emu) else $error("emulator branch wrong");
   a_wdt: assert property (p_wdt) else $error("watchdog reset missed");
   a_pin: assert property (p_pin) else $error("pin reset missed");
   a_rst_gm: assert property (p_rst_gm) else $error("mask open in reset");
   a_vcode: assert property (p_vcode) else $error("unknown vector code");
   a_bus: assert property (p_bus) else $error("bus answer not okay");
endmodule
bind cie_top cie_top_assertions u_chk (
   .clk_i(clk_i), .resetn_i(resetn_i), .en_i(en_i),
   .hreadyout_o(hreadyout_o), .hresp_o(hresp_o),
   .reset_pin_n_i(reset_pin_n_i), .watchdog_timeout_i(watchdog_timeout_i),
   .sw_interrupt_instr_i(sw_interrupt_instr_i), .sw_interrupt_vec_i(sw_interrupt_vec_i),
   .nmi_instr_i(nmi_instr_i), .trap_instr_i(trap_instr_i), .emu_trap_req_i(emu_trap_req_i),
   .cpu_reset_o(cpu_reset_o), .branch_o(branch_o),
   .peripheral_vector_code_o(peripheral_vector_code_o),
   .global_irq_mask_flag_o(global_irq_mask_flag_o));
`default_nettype wire

// file: testbench/cie_top_bench.sv
// testbench of cie_top: bus, instruction, source and reset scenarios
// assumes cie_src_model as far side and the bound checker
`timescale 1ns/100ps
`default_nettype none
module cie_top_bench
   import cie_pkg::*;
;
   // ************************************************************
   // stimulus and wiring
   // ************************************************************
   logic           clk_i = 1'b0;
   logic           resetn_i = 1'b0;
   logic           hsel_i = 1'b0;
   logic           hwrite_i = 1'b0;
   logic [1:0]     htrans_i = 2'h0;
   logic [7:0]     haddr_i = 8'h00;
   logic [31:0]    hwdata_i = 32'h0;
   logic           pin_n = 1'b1;
   logic           wdt = 1'b0;
   logic [3:0]     ins = 4'h0;
   logic [15:0]    ivec = 16'h0010;
   logic [4:0]     olr = 5'h00;
   logic [7:0]     fire = 8'h00;
   logic [7:0]     src;
   logic [31:0]    hrdata_o;
   logic           hreadyout_o;
   logic [5:0]     lines;
   logic [15:0]    vcode;
   logic           cpu_rst;
   logic           gmask;
   cie_branch_type branch;
   int             err_count = 0;
   int             total_checks = 0;
   always #4 clk_i = ~clk_i;
   cie_src_model u_src (.clk_i(clk_i), .fire_i(fire), .src_o(src));
   cie_top u_dut (
      .clk_i(clk_i), .resetn_i(resetn_i), .en_i(1'b1), .hsel_i(hsel_i),
      .haddr_i(haddr_i), .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hsize_i(3'h2),
      .hwdata_i(hwdata_i), .hready_i(hreadyout_o), .hrdata_o(hrdata_o),
      .hreadyout_o(hreadyout_o), .hresp_o(), .reset_pin_n_i(pin_n),
      .ext_pin_irq_a_i(src[3]), .ext_pin_irq_b_i(src[4]),
      .power_protect_irq_a_i(src[0]), .power_protect_irq_b_i(src[1]),
      .watchdog_timeout_i(wdt), .converter_irq_i(src[2]), .serial_periph_irq_i(src[5]),
      .serial_rx_irq_i(src[6]), .serial_tx_irq_i(src[7]), .other_line_req_i(olr),
      .sw_interrupt_instr_i(ins[3]), .sw_interrupt_vec_i(ivec), .nmi_instr_i(ins[2]),
      .trap_instr_i(ins[1]), .emu_trap_req_i(ins[0]), .cpu_reset_o(cpu_rst),
      .branch_o(branch), .core_irq_lines_o(lines), .peripheral_vector_code_o(vcode),
      .global_irq_mask_flag_o(gmask));
   // ************************************************************
   // tasks
   // ************************************************************
   task automatic close_out;
      $display("checks %0d errors %0d", total_checks, err_count);
      if (err_count == 0 && total_checks > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
      total_checks++;
      if (got !== ex) begin
         err_count++;
         $display("ERROR %s expected %h seen %h", nm, ex, got);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge clk_i);
      #1;
   endtask
   task automatic wait_rdy;
      int n;
      n = 0;
      do begin
         @(posedge clk_i);
         n++;
      end while (hreadyout_o !== 1'b1 && n < 64);
      if (n >= 64) begin
         chk("hready_wait", 32'h1, 32'h0);
         close_out;
      end
   endtask
   // one single word transfer; the slave sets the pace
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q);
      @(posedge clk_i);
      hsel_i <= 1'b1;
      haddr_i <= a;
      hwrite_i <= w;
      htrans_i <= 2'h2;
      wait_rdy;
      htrans_i <= 2'h0;
      hwdata_i <= d;
      wait_rdy;
      q = hrdata_o;
      hsel_i <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      bus(1'b1, a, d, q);
   endtask
   task automatic rd(input string nm, input logic [7:0] a, input logic [31:0] ex);
      logic [31:0] q;
      bus(1'b0, a, 32'h0, q);
      chk(nm, ex, q);
   endtask
   task automatic pulse(input logic [7:0] f);
      @(posedge clk_i);
      fire <= f;
      @(posedge clk_i);
      fire <= 8'h00;
      tick(6);
   endtask
   task automatic br(input logic [3:0] k, input logic [15:0] ev, input logic eg);
      @(posedge clk_i);
      ins <= k;
      @(posedge clk_i);
      ins <= 4'h0;
      #1 chk("branch", {1'b1, ev}, branch);
      chk("gmask", eg, gmask);
      tick(1);
      chk("branch_pulse", 1'b0, branch.valid);
   endtask
   task automatic t_branch;
      wr(CIE_OFS_GMASK, 32'h0);
      br(4'b0010, 16'h0022, 1'b0);
      br(4'b0011, 16'h0026, 1'b0);
      br(4'b1000, 16'h0010, 1'b1);
      wr(CIE_OFS_GMASK, 32'h0);
      br(4'b0100, 16'h0024, 1'b1);
      wr(CIE_OFS_GMASK, 32'h0);
      br(4'b1100, 16'h0024, 1'b1);
      wr(CIE_OFS_GMASK, 32'h0);
      br(4'b1101, 16'h0026, 1'b1);
      rd("gmask_reg", CIE_OFS_GMASK, 32'h1);
   endtask
   // all sources at once, then acked in priority order
   task automatic t_fold;
      logic [15:0] code [8] = '{16'h0020, 16'h0019, 16'h0004, 16'h0001,
                                16'h0011, 16'h0005, 16'h0006, 16'h0007};
      int          pos [8] = '{0, 16, 1, 2, 3, 4, 5, 6};
      logic [31:0] left;
      left = 32'h0001_007f;
      wr(CIE_OFS_ENABLE, left);
      wr(CIE_OFS_MASK, 32'h1);
      pulse(8'hff);
      for (int i = 0; i < 8; i++) begin
         chk("vcode", code[i], vcode);
         chk("line_one", 1'b1, lines[0]);
         rd("flag", CIE_OFS_FLAG, left);
         left[pos[i]] = 1'b0;
         wr(CIE_OFS_ACK, 32'h1 << pos[i]);
         tick(2);
      end
      chk("vcode_none", 16'h0, vcode);
      chk("line_one_off", 1'b0, lines[0]);
   endtask
   task automatic t_gate;
      wr(CIE_OFS_ENABLE, 32'h0);
      pulse(8'hff);
      rd("flag_off", CIE_OFS_FLAG, 32'h0);
      wr(CIE_OFS_ENABLE, 32'h4);
      wr(CIE_OFS_MASK, 32'h0);
      pulse(8'h08);
      chk("masked", 6'h0, lines);
      wr(CIE_OFS_MASK, 32'h3f);
      olr <= 5'h1f;
      tick(2);
      chk("lines", 6'h3f, lines);
      chk("vcode_pin_a", 16'h0001, vcode);
      rd("vcode_reg", CIE_OFS_CODE, 32'h1);
      rd("lines_reg", CIE_OFS_LINES, 32'h3f);
      wr(CIE_OFS_ACK, 32'h4);
      olr <= 5'h00;
      tick(2);
      chk("lines_off", 6'h0, lines);
   endtask
   task automatic t_rst(input logic by_pin);
      logic seen;
      seen = 1'b0;
      wr(CIE_OFS_GMASK, 32'h0);
      wr(CIE_OFS_MASK, 32'h3f);
      pin_n <= !by_pin;
      wdt <= !by_pin;
      for (int n = 0; n < 8; n++) begin
         @(posedge clk_i);
         wdt <= 1'b0;
         if (n == 3) begin
            pin_n <= 1'b1;
         end
         #1 seen = seen | (cpu_rst === 1'b1);
      end
      chk("cpu_reset", 1'b1, seen);
      for (int n = 0; n < 16 && cpu_rst !== 1'b0; n++) tick(1);
      chk("cpu_reset_end", 1'b0, cpu_rst);
      chk("gmask_rst", 1'b1, gmask);
      rd("mask_rst", CIE_OFS_MASK, 32'h0);
   endtask
   // ************************************************************
   // main sequence
   // ************************************************************
   initial begin
      repeat (12) @(posedge clk_i);
      resetn_i <= 1'b1;
      tick(1);
      chk("gmask_init", 1'b1, gmask);
      chk("lines_init", 6'h0, lines);
      tick(2);
      chk("cpu_reset_init", 1'b0, cpu_rst);
      rd("mask_init", CIE_OFS_MASK, 32'h0);
      rd("unmapped", 8'h40, 32'h0);
      t_branch;
      t_fold;
      t_gate;
      t_rst(1'b1);
      t_rst(1'b0);
      close_out;
   end
endmodule
`default_nettype wire
